// file: bench/encoder_signal_monitor_tb_top.sv
`timescale 1ns/100ps
module encoder_signal_monitor_tb_top;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, er, tr;
	logic        temp_valid, ser_wait, mode_cmd_valid, cd_valid, ab_valid, spd_sample, corr_valid, cub_min, cub_max;
	logic [7:0]  paddr, corr_ratio, corr_phase;
	logic [31:0] pwdata, prdata, lf, rd;
	logic [15:0] temp_tenths, track_c, track_d, ab_amp, ab_angle, spd_value, corr_off_a, corr_off_b;
	logic [12:0] ser_evt;
	logic [2:0]  mode_cmd;
	wire         ref_mark_pin, inc_pulse, ser_start, ser_bit, ser_frame_end, frame_valid, frame_fault, frame_alarm;
	wire  [15:0] frame_supp, frame_cause;
	wire         cd_start_ok, alarm_active;
	int          fails, comparisons, cyc, v, pv, run, pd, e;
	int ra[5] = '{0, 8, 12, 16, 20};
	int rv[5] = '{4, 2048, 2048, 256, 3};
	int tv[3] = '{1250, 1251, 300};
	logic signed [15:0] cc[4] = '{16'h5333, 16'h7fff, 16'h0064, 16'h5333};
	logic signed [15:0] cd[4] = '{16'h0000, 16'h0000, 16'h00c8, 16'h0000};
	int av[5] = '{4898, 4899, 6389, 6390, 10650};
	int cr[11] = '{100, 100, 100, 100, 128, 77, 100, 100, 100, 100, 78};
	int cp[11] = '{90, 90, 90, 90, 90, 90, 97, 83, 90, 90, 84};
	int ca[11] = '{0, 0, 140, -140, 0, 0, 0, 0, 0, 0, 139};
	int cb[11] = '{140, -140, 0, 0, 0, 0, 0, 0, 0, 0, -139};
	int cm[11] = '{0, 0, 0, 0, 0, 0, 0, 0, 2, 1, 0};
	esm_encoder_signal_monitor #(.START_TO_CYC(23'd20)) uut (.*);
	esm_encoder_model enc (.*);
	initial begin
		pclk = 0;
		forever #5 pclk = ~pclk;
	end
	always @(posedge pclk) begin
		cyc <= cyc + 1;
		if (cyc == 30000) begin
			fails++;
			conclude();
		end
	end
	function automatic logic [31:0] nx(logic [31:0] x);
		return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
	endfunction
	function automatic bit cdt(int c, int d);
		return c * c + d * d < 9797 * 9797 || c * c + d * d > 31948 * 31948;
	endfunction
	function automatic int cval(int i);
		return (cb[i] >= 140 ? 2 : cb[i] <= -140 ? 1 : 0) | (ca[i] >= 140 ? 32 : ca[i] <= -140 ? 16 : 0)
			| (cr[i] > 127 ? 512 : cr[i] < 78 ? 256 : 0) | (cp[i] > 96 ? 8192 : cp[i] < 84 ? 4096 : 0)
			| (cm[i] == 2 ? 131072 : cm[i] == 1 ? 65536 : 0);
	endfunction
	task automatic chk(string n, logic [31:0] x, logic [31:0] g);
		comparisons++;
		if (g !== x) begin
			fails++;
			$display("wrong value %0s expected %h seen %h", n, x, g);
		end
	endtask
	task automatic apb(logic w, logic [7:0] a, logic [31:0] d);
		@(posedge pclk);
		{psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
		@(posedge pclk);
		penable <= 1;
		// Request holds until the rising edge that samples ready high
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		{psel, penable} <= 2'b00;
	endtask
	task automatic rdc(string n, logic [7:0] a, logic [31:0] x);
		apb(0, a, 0);
		chk(n, x, rd);
	endtask
	task automatic w(int n);
		repeat (n) @(posedge pclk);
	endtask
	task automatic ack;
		apb(1, 8'h04, 32'h0000_01ff);
		w(4);
	endtask
	task automatic stat(int b, logic x);
		apb(0, 8'h04, 0);
		chk("stat_flag", x, rd[b]);
	endtask
	// Bit 5 temp, 4 cd, 3 ab, 2 speed, 1 corr, 0 mode
	task automatic strobe(int k);
		@(posedge pclk);
		{temp_valid, cd_valid, ab_valid, spd_sample, corr_valid, mode_cmd_valid} <= 6'(1 << k);
		@(posedge pclk);
		{temp_valid, cd_valid, ab_valid, spd_sample, corr_valid, mode_cmd_valid} <= 6'h00;
		w(4);
	endtask
	task automatic conclude;
		$display("comparisons %0d fails %0d", comparisons, fails);
		if (fails == 0 && comparisons > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	initial begin
		{psel, penable, pwrite, temp_valid, ser_wait, mode_cmd_valid, cd_valid, ab_valid} = 0;
		{spd_sample, corr_valid, cub_min, cub_max, ser_evt, mode_cmd, paddr, pwdata} = 0;
		{temp_tenths, track_c, track_d, ab_amp, ab_angle, spd_value, corr_off_a, corr_off_b} = 0;
		{corr_ratio, corr_phase} = {8'h64, 8'h5a};
		lf = 32'h0000_55d3;
		presetn = 0;
		repeat (12) @(posedge pclk);
		presetn <= 1;
		for (int i = 0; i < 5; i++) rdc("reset_value", 8'(ra[i]), rv[i]);
		apb(0, 8'h20, 0);
		chk("unmapped_err", 1, er);
		apb(1, 8'h18, 1);
		chk("readonly_err", 1, er);
		lf = nx(lf);
		apb(1, 8'h0c, lf);
		rdc("lin_spacing", 8'h0c, lf);
		$display("test registers done");
		apb(1, 8'h08, 8);
		enc.incs(5);
		enc.mark();
		ack();
		enc.incs(12);
		w(4);
		stat(0, 2 * 12 > 3 * 8);
		enc.incs(1);
		w(4);
		stat(0, 2 * 13 > 3 * 8);
		rdc("mark_count", 8'h40, 13);
		enc.mark();
		ack();
		$display("test ref_mark done");
		for (int i = 0; i < 3; i++) begin
			temp_tenths <= 16'(tv[i]);
			strobe(5);
			if (i < 2) stat(1, tv[i] > 1250);
		end
		rdc("temp_slot", 8'h44, 1251);
		rdc("fault_word", 8'h18, 1251);
		ack();
		stat(1, 0);
		$display("test temperature done");
		for (int b = 0; b < 13; b++) if (b inside {0, 1, 3, 4, 9, 10, 11, 12}) begin
			ack();
			ser_evt <= 13'(1 << b);
			@(posedge pclk);
			ser_evt <= 0;
			w(4);
			apb(0, 8'h48, 0);
			chk("ser_bit", 1, rd[b]);
		end
		for (int m = 0; m < 8; m++) begin
			ack();
			mode_cmd <= 3'(m);
			strobe(0);
			stat(2, m > 4);
		end
		apb(0, 8'h48, 0);
		chk("mode_bit", 1, rd[5]);
		ack();
		ser_wait <= 1;
		w(12);
		stat(2, 0);
		w(12);
		ser_wait <= 0;
		w(3);
		apb(0, 8'h48, 0);
		chk("timeout_bit", 1, rd[2]);
		for (int n = 64; n < 66; n++) begin
			ack();
			enc.frame(n, 0, 0, 0, 0);
			w(4);
			stat(2, n > 64);
		end
		$display("test serial done");
		for (int k = 0; k < 3; k++) begin
			ack();
			lf = nx(lf) | 1;
			enc.frame(16, 16'(k), lf[15:0], k == 0, k == 1);
			w(4);
			stat(3, k < 2);
			if (k < 2) rdc("detail_word", 8'h4c, {16'(k), lf[15:0] & (k ? 16'h00ff : 16'h001f)});
			if (k < 2) rdc("simple_word", 8'h50, k ? 2 : 1);
		end
		ack();
		$display("test encoder_alarm done");
		for (int i = 0; i < 4; i++) begin
			{track_c, track_d} <= {cc[i], cd[i]};
			strobe(4);
			ack();
			tr = cdt(cc[i], cd[i]);
			chk("cd_start_ok", !tr, cd_start_ok);
			stat(5, tr);
			if (tr) rdc("cd_word", 8'h54, {cd[i], cc[i]});
		end
		for (int i = 0; i < 5; i++) begin
			apb(1, 8'h00, (i == 2 || i == 3) ? 6 : 4);
			lf = nx(lf);
			{ab_amp, ab_angle} <= {16'(av[i]), lf[15:0]};
			strobe(3);
			ack();
			tr = av[i] < ((i == 2 || i == 3) ? 6390 : 4899);
			stat(6, tr);
			if (tr) rdc("ab_word", 8'h58, {lf[15:0], 16'(av[i])});
		end
		$display("test track_level done");
		apb(1, 8'h10, 16);
		apb(1, 8'h14, 3);
		for (int i = 0; i < 6; i++) begin
			v = i < 4 ? 20 * i : 60;
			spd_value <= 16'(v);
			strobe(2);
			pd = v > pv ? v - pv : pv - v;
			run = pd > 16 ? run + 1 : 0;
			pv = v;
			if (i < 4) stat(7, run >= 3);
			if (i == 3) rdc("speed_delta", 8'h5c, pd);
		end
		ack();
		stat(7, 0);
		$display("test speed done");
		for (int i = 0; i < 11; i++) begin
			{corr_ratio, corr_phase} <= {8'(cr[i]), 8'(cp[i])};
			{corr_off_a, corr_off_b} <= {16'(ca[i]), 16'(cb[i])};
			{cub_max, cub_min} <= 2'(cm[i]);
			strobe(1);
			ack();
			e = cval(i);
			stat(8, e != 0);
			if (e != 0) rdc("corr_word", 8'h60, e);
		end
		$display("test correction done");
		conclude();
	end
endmodule

// file: bench/esm_checker.sv
`timescale 1ns/100ps
module esm_checker #(
	parameter [22:0] START_TO_CYC = 23'd20
) (
	// Clock and reset
	input wire        pclk,
	input wire        presetn,
	// APB
	input wire        psel,
	input wire        penable,
	input wire        pwrite,
	input wire [7:0]  paddr,
	input wire [31:0] prdata,
	input wire        pready,
	input wire        pslverr,
	// Sources
	input wire        temp_valid,
	input wire [15:0] temp_tenths,
	input wire        ser_wait,
	input wire        ser_start,
	input wire        mode_cmd_valid,
	input wire [2:0]  mode_cmd,
	input wire        cd_valid,
	input wire [15:0] track_c,
	input wire [15:0] track_d,
	// Status
	input wire        cd_start_ok,
	input wire        alarm_active
);
	reg  [23:0] wait_cnt_ff;
	wire [23:0] nxt_wait_cnt = (ser_wait && !ser_start) ? wait_cnt_ff + 24'h00_0001 : 24'h00_0000;
	always @(posedge pclk or negedge presetn) begin
		if (!presetn)
			wait_cnt_ff <= 24'h00_0000;
		else
			wait_cnt_ff <= nxt_wait_cnt;
	end
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	one_wait_a: assert property (pready |-> psel && penable && $past(psel && penable))
		else $error("ready without one wait state");
	ready_pulse_a: assert property (pready |=> !pready) else $error("ready longer than one cycle");
	err_ready_a: assert property (pslverr |-> pready) else $error("error flag without ready");
	unmapped_err_a: assert property (psel && penable && !pwrite && paddr == 8'h20 && !pready |=> pready && pslverr)
		else $error("unmapped read not refused");
	read_hold_a: assert property ($changed(prdata) |-> pready) else $error("read data moved");
	temp_trip_a: assert property (temp_valid && temp_tenths > 16'h04e2 |-> ##[1:4] alarm_active)
		else $error("over temperature not flagged");
	mode_cmd_a: assert property (mode_cmd_valid && mode_cmd > 3'h4 |-> ##[1:4] alarm_active)
		else $error("illegal mode not flagged");
	start_timeout_a: assert property (wait_cnt_ff == START_TO_CYC + 24'h00_0004 |-> alarm_active)
		else $error("start bit timeout not flagged");
	cd_band_a: assert property (cd_valid && track_c == 16'h7fff && track_d == 16'h0000 |-> ##[1:3] !cd_start_ok)
		else $error("out of band level used for start");
	cover property (pslverr);
	cover property ($rose(alarm_active));
	cover property ($rose(cd_start_ok));
endmodule
bind esm_encoder_signal_monitor esm_checker #(.START_TO_CYC(START_TO_CYC)) chk (.*);

// file: bench/esm_encoder_model.sv
`timescale 1ns/100ps
module esm_encoder_model (
	// Clock
	input  wire         pclk,
	// Incremental tracks
	output logic        ref_mark_pin,
	output logic        inc_pulse,
	// Serial frame
	output logic        ser_start,
	output logic        ser_bit,
	output logic        ser_frame_end,
	output logic        frame_valid,
	output logic [15:0] frame_supp,
	output logic [15:0] frame_cause,
	output logic        frame_fault,
	output logic        frame_alarm
);
	initial {ref_mark_pin, inc_pulse, ser_start, ser_bit, ser_frame_end, frame_valid} = 0;
	initial {frame_supp, frame_cause, frame_fault, frame_alarm} = 0;
	task automatic incs(int n);
		repeat (n) begin
			@(posedge pclk);
			inc_pulse <= 1;
			@(posedge pclk);
			inc_pulse <= 0;
		end
	endtask
	task automatic mark;
		@(posedge pclk);
		ref_mark_pin <= 1;
		repeat (6) @(posedge pclk);
		ref_mark_pin <= 0;
		repeat (6) @(posedge pclk);
	endtask
	task automatic frame(int n, logic [15:0] s, logic [15:0] c, logic f, logic a);
		@(posedge pclk);
		ser_start <= 1;
		@(posedge pclk);
		ser_start <= 0;
		repeat (n) begin
			ser_bit <= 1;
			@(posedge pclk);
			ser_bit <= 0;
			@(posedge pclk);
		end
		{ser_frame_end, frame_valid} <= 2'b11;
		{frame_supp, frame_cause, frame_fault, frame_alarm} <= {s, c, f, a};
		@(posedge pclk);
		{ser_frame_end, frame_valid} <= 2'b00;
		// Released content shows garbage, not the last value
		{frame_supp, frame_cause, frame_fault, frame_alarm} <= ~{s, c, f, a};
	endtask
endmodule

// file: logic/esm_encoder_map.vh
`ifndef ESM_ENCODER_MAP_VH
`define ESM_ENCODER_MAP_VH

// Register byte offsets
`define ESM_OFF_CTRL      8'h00
`define ESM_OFF_STAT      8'h04
`define ESM_OFF_REF_ROT   8'h08
`define ESM_OFF_REF_LIN   8'h0c
`define ESM_OFF_SPD_LIM   8'h10
`define ESM_OFF_SPD_CNT   8'h14
`define ESM_OFF_FAULT     8'h18
`define ESM_OFF_SER_LIVE  8'h1c
`define ESM_VAL_REGION    2'h1

// Reset values
`define ESM_RST_CTRL      3'h4
`define ESM_RST_REF       32'h0000_0800
`define ESM_RST_SPD_LIM   16'h0100
`define ESM_RST_SPD_CNT   8'h03

// Control fields
`define ESM_CTRL_LINEAR   0
`define ESM_CTRL_RESOLVER 1
`define ESM_CTRL_EN       2

// Alarm slots
`define ESM_AL_REF        0
`define ESM_AL_TEMP       1
`define ESM_AL_SER        2
`define ESM_AL_DET        3
`define ESM_AL_SIMP       4
`define ESM_AL_CD         5
`define ESM_AL_AB         6
`define ESM_AL_SPD        7
`define ESM_AL_CORR       8
`define ESM_NUM_AL        9

// Serial error word
`define ESM_SER_EXT_MASK  13'h1e1b
`define ESM_SER_TIMEOUT   2
`define ESM_SER_MODE      5
`define ESM_SER_LONG      8
`define ESM_MAX_FRAME     7'h40
`define ESM_MODE_MAX      3'h4
`define ESM_START_TO_MS   50
`define ESM_CLK_MHZ       100

// Encoder alarm words
`define ESM_SUPP_STD      16'h0000
`define ESM_SUPP_EXT      16'h0001
`define ESM_MASK_STD      16'h001f
`define ESM_MASK_EXT      16'h00ff

// Temperature in tenths of a degree (125.0 C)
`define ESM_TEMP_LIM      16'h04e2

// Track levels: nominal code and millivolt figures
`define ESM_CD_NOM        32'h0000_5333
`define ESM_CD_NOM_MV     32'h0000_01f4
`define ESM_CD_LO_MV      32'h0000_00e6
`define ESM_CD_HI_MV      32'h0000_02ee
`define ESM_AB_NOM        32'h0000_299a
`define ESM_AB_NOM_MV     32'h0000_01f4
`define ESM_AB_LO_MV      32'h0000_00e6
`define ESM_RES_NOM       32'h0000_3333
`define ESM_RES_NOM_MV    32'h0000_0b54
`define ESM_RES_LO_MV     32'h0000_0586

// Track correction limits (ratio in hundredths, phase in degrees, offset in mV)
`define ESM_RATIO_MIN     8'h4e
`define ESM_RATIO_MAX     8'h7f
`define ESM_PHASE_MIN     8'h54
`define ESM_PHASE_MAX     8'h60
`define ESM_OFF_LIM_P     16'h008c
`define ESM_OFF_LIM_N     16'hff74
`define ESM_DIG_OFFB      0
`define ESM_DIG_OFFA      4
`define ESM_DIG_AMP       8
`define ESM_DIG_PHASE     12
`define ESM_DIG_CUBIC     16
`define ESM_DIG_MIN       4'h1
`define ESM_DIG_MAX       4'h2

`endif

// file: logic/esm_encoder_signal_monitor.v
`timescale 1ns/100ps
`include "esm_encoder_map.vh"

module esm_encoder_signal_monitor #(
	parameter [22:0] START_TO_CYC = `ESM_START_TO_MS * 1000 * `ESM_CLK_MHZ
) (
	// Clock and reset
	input  wire        pclk,
	input  wire        presetn,
	// APB slave
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [7:0]  paddr,
	input  wire [31:0] pwdata,
	output wire [31:0] prdata,
	output wire        pready,
	output wire        pslverr,
	// Incremental position
	input  wire        ref_mark_pin,
	input  wire        inc_pulse,
	// Module temperature
	input  wire        temp_valid,
	input  wire [15:0] temp_tenths,
	// Serial link events
	input  wire [12:0] ser_evt,
	input  wire        ser_wait,
	input  wire        ser_start,
	input  wire        ser_bit,
	input  wire        ser_frame_end,
	input  wire        mode_cmd_valid,
	input  wire [2:0]  mode_cmd,
	// Encoder frame alarm content
	input  wire        frame_valid,
	input  wire [15:0] frame_supp,
	input  wire [15:0] frame_cause,
	input  wire        frame_fault,
	input  wire        frame_alarm,
	// Track levels
	input  wire        cd_valid,
	input  wire [15:0] track_c,
	input  wire [15:0] track_d,
	input  wire        ab_valid,
	input  wire [15:0] ab_amp,
	input  wire [15:0] ab_angle,
	// Speed samples
	input  wire        spd_sample,
	input  wire [15:0] spd_value,
	// Track correction state
	input  wire        corr_valid,
	input  wire [7:0]  corr_ratio,
	input  wire [7:0]  corr_phase,
	input  wire [15:0] corr_off_a,
	input  wire [15:0] corr_off_b,
	input  wire        cub_min,
	input  wire        cub_max,
	// Status
	output wire        cd_start_ok,
	output wire        alarm_active
);

	localparam integer CD_LO  = `ESM_CD_NOM * `ESM_CD_LO_MV / `ESM_CD_NOM_MV;
	localparam integer CD_HI  = `ESM_CD_NOM * `ESM_CD_HI_MV / `ESM_CD_NOM_MV;
	localparam integer AB_LO  = `ESM_AB_NOM * `ESM_AB_LO_MV / `ESM_AB_NOM_MV;
	localparam integer RES_LO = `ESM_RES_NOM * `ESM_RES_LO_MV / `ESM_RES_NOM_MV;
	localparam [32:0]  CD_LO_SQ = {1'b0, CD_LO * CD_LO};
	localparam [32:0]  CD_HI_SQ = {1'b0, CD_HI * CD_HI};
	localparam [15:0]  AB_LO_W  = AB_LO[15:0];
	localparam [15:0]  RES_LO_W = RES_LO[15:0];

	// Lowest pending slot, bit 4 flags that one exists
	function [4:0] esm_first;
		input [8:0] v;
		integer i;
		begin
			esm_first = 5'h00;
			for (i = 8; i >= 0; i = i - 1) begin
				if (v[i]) begin
					esm_first = {1'b1, i[3:0]};
				end
			end
		end
	endfunction

	// One correction digit
	function [3:0] esm_digit;
		input lo;
		input hi;
		begin
			esm_digit = hi ? `ESM_DIG_MAX : (lo ? `ESM_DIG_MIN : 4'h0);
		end
	endfunction

	// Bus state
	reg        pready_ff;
	reg        pslverr_ff;
	reg [31:0] prdata_ff;
	reg [2:0]  ctrl_ff;
	reg [31:0] ref_rot_ff;
	reg [31:0] ref_lin_ff;
	reg [15:0] spd_lim_ff;
	reg [7:0]  spd_cnt_cfg_ff;
	reg [31:0] fault_value_word_ff;
	reg [8:0]  flags_ff;
	reg        alarm_active_ff;

	// Monitor state
	reg [2:0]  ref_sync_ff;
	reg        ref_stable_ff;
	reg [31:0] inc_cnt_ff;
	reg [15:0] temp_ff;
	reg [12:0] ser_err_ff;
	reg [22:0] start_to_ff;
	reg [6:0]  bit_cnt_ff;
	reg        in_frame_ff;
	reg [31:0] det_ff;
	reg [1:0]  simp_ff;
	reg        cd_seen_ff;
	reg [15:0] cd_c_ff;
	reg [15:0] cd_d_ff;
	reg        cd_start_ok_ff;
	reg        ab_seen_ff;
	reg [15:0] ab_amp_ff;
	reg [15:0] ab_ang_ff;
	reg [15:0] spd_prev_ff;
	reg [15:0] spd_delta_ff;
	reg [7:0]  spd_run_ff;
	reg [19:0] corr_word_ff;

	wire        acc      = psel & penable;
	wire        wr_go    = acc & pwrite & pready_ff;
	wire        in_val   = (paddr[7:6] == `ESM_VAL_REGION);
	wire [31:0] ram_rd;
	wire [8:0]  clr      = (wr_go && paddr == `ESM_OFF_STAT) ? pwdata[8:0] : 9'h000;
	wire [31:0] ref_spc  = ctrl_ff[`ESM_CTRL_LINEAR] ? ref_lin_ff : ref_rot_ff;

	// Reference mark pin filter
	wire        ref_agree = (ref_sync_ff[1] == ref_sync_ff[2]);
	wire        ref_edge  = ref_agree & ref_sync_ff[2] & ~ref_stable_ff;

	// Travel limit is 1.5x spacing: compare 2*count against 3*spacing
	wire [33:0] ref_lim  = {2'b00, ref_spc} + {1'b0, ref_spc, 1'b0};
	wire        cond_ref = ({1'b0, inc_cnt_ff, 1'b0} > ref_lim);

	wire        cond_temp = (temp_ff > `ESM_TEMP_LIM);

	// Serial error word sources
	wire        to_hit    = ser_wait & ~ser_start & (start_to_ff == START_TO_CYC - 23'h00_0001);
	wire        mode_bad  = mode_cmd_valid & (mode_cmd > `ESM_MODE_MAX);
	wire        too_long  = in_frame_ff & ser_bit & (bit_cnt_ff == `ESM_MAX_FRAME);
	reg  [12:0] ser_new;
	always @* begin
		ser_new = ser_evt & `ESM_SER_EXT_MASK;
		ser_new[`ESM_SER_TIMEOUT] = to_hit;
		ser_new[`ESM_SER_MODE] = mode_bad;
		ser_new[`ESM_SER_LONG] = too_long;
	end
	wire        cond_ser = |ser_err_ff;

	// Detailed encoder alarm
	wire [15:0] det_mask = (frame_supp == `ESM_SUPP_STD) ? `ESM_MASK_STD :
	                       (frame_supp == `ESM_SUPP_EXT) ? `ESM_MASK_EXT : 16'h0000;
	wire [15:0] det_bits = frame_cause & det_mask;
	wire        det_new  = frame_valid & (|det_bits);
	wire        cond_det = |det_ff[15:0];
	wire [1:0]  simp_new = frame_valid ? {frame_alarm, frame_fault} : 2'b00;
	wire        cond_simp = |simp_ff;

	// C/D amplitude as sum of squares
	wire signed [31:0] c_sq   = $signed(cd_c_ff) * $signed(cd_c_ff);
	wire signed [31:0] d_sq   = $signed(cd_d_ff) * $signed(cd_d_ff);
	wire        [32:0] cd_sum = {1'b0, c_sq} + {1'b0, d_sq};
	wire        cd_out  = (cd_sum < CD_LO_SQ) | (cd_sum > CD_HI_SQ);
	wire        cond_cd = cd_seen_ff & cd_out;

	wire [15:0] ab_lo   = ctrl_ff[`ESM_CTRL_RESOLVER] ? RES_LO_W : AB_LO_W;
	wire        cond_ab = ab_seen_ff & (ab_amp_ff < ab_lo);

	// Speed change
	wire [15:0] spd_diff = spd_value - spd_prev_ff;
	wire [15:0] spd_abs  = spd_diff[15] ? (16'h0000 - spd_diff) : spd_diff;
	wire        cond_spd = (spd_cnt_cfg_ff != 8'h00) & (spd_run_ff >= spd_cnt_cfg_ff);

	// Correction limit word
	wire [19:0] corr_new;
	assign corr_new[`ESM_DIG_OFFB+3:`ESM_DIG_OFFB] = esm_digit(
		$signed(corr_off_b) <= $signed(`ESM_OFF_LIM_N), $signed(corr_off_b) >= $signed(`ESM_OFF_LIM_P));
	assign corr_new[`ESM_DIG_OFFA+3:`ESM_DIG_OFFA] = esm_digit(
		$signed(corr_off_a) <= $signed(`ESM_OFF_LIM_N), $signed(corr_off_a) >= $signed(`ESM_OFF_LIM_P));
	assign corr_new[`ESM_DIG_AMP+3:`ESM_DIG_AMP] = esm_digit(
		corr_ratio < `ESM_RATIO_MIN, corr_ratio > `ESM_RATIO_MAX);
	assign corr_new[`ESM_DIG_PHASE+3:`ESM_DIG_PHASE] = esm_digit(
		corr_phase < `ESM_PHASE_MIN, corr_phase > `ESM_PHASE_MAX);
	assign corr_new[`ESM_DIG_CUBIC+3:`ESM_DIG_CUBIC] = esm_digit(cub_min, cub_max);
	wire        cond_corr = |corr_word_ff;

	// Alarm values per slot
	wire [31:0] val [0:8];
	assign val[`ESM_AL_REF]  = inc_cnt_ff;
	assign val[`ESM_AL_TEMP] = {16'h0000, temp_ff};
	assign val[`ESM_AL_SER]  = {19'h0_0000, ser_err_ff};
	assign val[`ESM_AL_DET]  = det_ff;
	assign val[`ESM_AL_SIMP] = {30'h0000_0000, simp_ff};
	assign val[`ESM_AL_CD]   = {cd_d_ff, cd_c_ff};
	assign val[`ESM_AL_AB]   = {ab_ang_ff, ab_amp_ff};
	assign val[`ESM_AL_SPD]  = {16'h0000, spd_delta_ff};
	assign val[`ESM_AL_CORR] = {12'h000, corr_word_ff};

	wire [8:0]  cond = {cond_corr, cond_spd, cond_ab, cond_cd, cond_simp, cond_det, cond_ser, cond_temp, cond_ref};
	// Only slots whose flag is clear are written, so a shown value never changes under software
	wire [8:0]  pend = cond & ~flags_ff & {9{ctrl_ff[`ESM_CTRL_EN]}};
	wire [4:0]  pick = esm_first(pend);
	wire        wr_en = pick[4];
	wire [8:0]  set_oh = wr_en ? (9'h001 << pick[3:0]) : 9'h000;
	wire [8:0]  nxt_flags = (flags_ff & ~clr) | set_oh;

	esm_value_ram u_ram (
		.pclk    (pclk),
		.presetn (presetn),
		.wr_en   (wr_en),
		.wr_idx  (pick[3:0]),
		.wr_data (val[pick[3:0]]),
		.rd_idx  (paddr[5:2]),
		.rd_data (ram_rd)
	);

	// Read mux and decode
	reg [31:0] nxt_rdata;
	reg        rd_hit;
	reg        wr_hit;
	always @* begin
		nxt_rdata = 32'h0000_0000;
		rd_hit = 1'b1;
		wr_hit = 1'b0;
		case (paddr)
			`ESM_OFF_CTRL: begin
				nxt_rdata = {29'h0000_0000, ctrl_ff};
				wr_hit = 1'b1;
			end
			`ESM_OFF_STAT: begin
				nxt_rdata = {23'h00_0000, flags_ff};
				wr_hit = 1'b1;
			end
			`ESM_OFF_REF_ROT: begin
				nxt_rdata = ref_rot_ff;
				wr_hit = 1'b1;
			end
			`ESM_OFF_REF_LIN: begin
				nxt_rdata = ref_lin_ff;
				wr_hit = 1'b1;
			end
			`ESM_OFF_SPD_LIM: begin
				nxt_rdata = {16'h0000, spd_lim_ff};
				wr_hit = 1'b1;
			end
			`ESM_OFF_SPD_CNT: begin
				nxt_rdata = {24'h00_0000, spd_cnt_cfg_ff};
				wr_hit = 1'b1;
			end
			`ESM_OFF_FAULT: nxt_rdata = fault_value_word_ff;
			`ESM_OFF_SER_LIVE: nxt_rdata = {19'h0_0000, ser_err_ff};
			default: begin
				nxt_rdata = in_val ? ram_rd : 32'h0000_0000;
				rd_hit = in_val;
			end
		endcase
	end

	// APB slave: one wait state, answer in second access cycle
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_ff <= 1'b0;
			pslverr_ff <= 1'b0;
			prdata_ff <= 32'h0000_0000;
			ctrl_ff <= `ESM_RST_CTRL;
			ref_rot_ff <= `ESM_RST_REF;
			ref_lin_ff <= `ESM_RST_REF;
			spd_lim_ff <= `ESM_RST_SPD_LIM;
			spd_cnt_cfg_ff <= `ESM_RST_SPD_CNT;
		end else begin
			pready_ff <= acc & ~pready_ff;
			if (acc && !pready_ff) begin
				pslverr_ff <= pwrite ? ~wr_hit : ~rd_hit;
				prdata_ff <= pwrite ? 32'h0000_0000 : nxt_rdata;
			end else begin
				pslverr_ff <= 1'b0;
			end
			if (wr_go) begin
				case (paddr)
					`ESM_OFF_CTRL: ctrl_ff <= pwdata[2:0];
					`ESM_OFF_REF_ROT: ref_rot_ff <= pwdata;
					`ESM_OFF_REF_LIN: ref_lin_ff <= pwdata;
					`ESM_OFF_SPD_LIM: spd_lim_ff <= pwdata[15:0];
					`ESM_OFF_SPD_CNT: spd_cnt_cfg_ff <= pwdata[7:0];
					default: ;
				endcase
			end
		end
	end

	// Flags, held values and latched sources
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			flags_ff <= 9'h000;
			alarm_active_ff <= 1'b0;
			fault_value_word_ff <= 32'h0000_0000;
			ser_err_ff <= 13'h0000;
			det_ff <= 32'h0000_0000;
			simp_ff <= 2'b00;
		end else begin
			flags_ff <= nxt_flags;
			alarm_active_ff <= |nxt_flags;
			if (set_oh[`ESM_AL_TEMP]) begin
				fault_value_word_ff <= val[`ESM_AL_TEMP];
			end
			// New events beat a same-cycle acknowledge
			ser_err_ff <= (clr[`ESM_AL_SER] ? 13'h0000 : ser_err_ff) | ser_new;
			simp_ff <= (clr[`ESM_AL_SIMP] ? 2'b00 : simp_ff) | simp_new;
			if (det_new) begin
				det_ff <= {frame_supp, det_bits};
			end else if (clr[`ESM_AL_DET]) begin
				det_ff <= 32'h0000_0000;
			end
		end
	end

	// Monitors
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ref_sync_ff <= 3'h0;
			ref_stable_ff <= 1'b0;
			inc_cnt_ff <= 32'h0000_0000;
			temp_ff <= 16'h0000;
			start_to_ff <= 23'h00_0000;
			bit_cnt_ff <= 7'h00;
			in_frame_ff <= 1'b0;
			cd_seen_ff <= 1'b0;
			cd_c_ff <= 16'h0000;
			cd_d_ff <= 16'h0000;
			cd_start_ok_ff <= 1'b0;
			ab_seen_ff <= 1'b0;
			ab_amp_ff <= 16'h0000;
			ab_ang_ff <= 16'h0000;
			spd_prev_ff <= 16'h0000;
			spd_delta_ff <= 16'h0000;
			spd_run_ff <= 8'h00;
			corr_word_ff <= 20'h0_0000;
		end else begin
			ref_sync_ff <= {ref_sync_ff[1:0], ref_mark_pin};
			if (ref_agree) begin
				ref_stable_ff <= ref_sync_ff[2];
			end
			if (ref_edge) begin
				inc_cnt_ff <= 32'h0000_0000;
			end else if (inc_pulse && inc_cnt_ff != 32'hffff_ffff) begin
				inc_cnt_ff <= inc_cnt_ff + 32'h0000_0001;
			end
			if (temp_valid) begin
				temp_ff <= temp_tenths;
			end
			if (!ser_wait || ser_start) begin
				start_to_ff <= 23'h00_0000;
			end else if (start_to_ff != START_TO_CYC) begin
				start_to_ff <= start_to_ff + 23'h00_0001;
			end
			if (ser_start) begin
				in_frame_ff <= 1'b1;
				bit_cnt_ff <= 7'h00;
			end else if (ser_frame_end) begin
				in_frame_ff <= 1'b0;
			end else if (in_frame_ff && ser_bit && bit_cnt_ff != `ESM_MAX_FRAME) begin
				bit_cnt_ff <= bit_cnt_ff + 7'h01;
			end
			if (cd_valid) begin
				cd_seen_ff <= 1'b1;
				cd_c_ff <= track_c;
				cd_d_ff <= track_d;
			end
			cd_start_ok_ff <= cd_seen_ff & ~cd_out;
			if (ab_valid) begin
				ab_seen_ff <= 1'b1;
				ab_amp_ff <= ab_amp;
				ab_ang_ff <= ab_angle;
			end
			if (spd_sample) begin
				spd_prev_ff <= spd_value;
				spd_delta_ff <= spd_abs;
				if (spd_abs > spd_lim_ff) begin
					if (spd_run_ff != 8'hff) begin
						spd_run_ff <= spd_run_ff + 8'h01;
					end
				end else begin
					spd_run_ff <= 8'h00;
				end
			end
			if (corr_valid) begin
				corr_word_ff <= corr_new;
			end
		end
	end

	assign prdata       = prdata_ff;
	assign pready       = pready_ff;
	assign pslverr      = pslverr_ff;
	assign cd_start_ok  = cd_start_ok_ff;
	assign alarm_active = alarm_active_ff;

endmodule

// file: logic/esm_value_ram.v
`timescale 1ns/100ps
`include "esm_encoder_map.vh"

module esm_value_ram (
	// Clock and reset
	input  wire        pclk,
	input  wire        presetn,
	// Write port
	input  wire        wr_en,
	input  wire [3:0]  wr_idx,
	input  wire [31:0] wr_data,
	// Read port
	input  wire [3:0]  rd_idx,
	output wire [31:0] rd_data
);

	reg [31:0] mem_ff [0:15];
	reg [31:0] rd_data_ff;

	always @(posedge pclk) begin
		if (wr_en) begin
			mem_ff[wr_idx] <= wr_data;
		end
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rd_data_ff <= 32'h0000_0000;
		end else begin
			rd_data_ff <= mem_ff[rd_idx];
		end
	end

	assign rd_data = rd_data_ff;

endmodule
